// >>> src/conv_ctl_map.vh
`ifndef CONV_CTL_MAP_VH
`define CONV_CTL_MAP_VH

// special-function register addresses
`define ADDR_RESULT_LOW 8'hbe
`define ADDR_RESULT_HIGH 8'hbf
`define ADDR_CONFIG 8'hbc
`define ADDR_CONTROL 8'he8

// converter_control_reg field positions
`define BIT_CONVERTER_ON 7
`define BIT_TRACK_SELECT 6
`define BIT_CONV_DONE 5
`define BIT_CONV_ACTIVE 4
`define BIT_SRC_HI 3
`define BIT_SRC_LO 2
`define BIT_WINDOW_HIT 1
`define BIT_JUSTIFY_LEFT 0

// configuration register: divider in bits 7-3, gain bits kept but unused here
`define CFG_DIV_HI 7
`define CFG_DIV_LO 3

// reset values
`define RST_CONTROL 8'h00
`define RST_RESULT 8'h00
`define RST_CONFIG 8'hf8

// start sources
`define SRC_WRITE 2'h0
`define SRC_TIMER3 2'h1
`define SRC_PIN 2'h2
`define SRC_TIMER2 2'h3

// timing in sar clocks
`define TRACK_SAR_CLOCKS 5'h03
`define CONV_SAR_CLOCKS 5'h10

`endif

// >>> src/sar_clk_div.v
`timescale 1ns/100ps
`default_nettype none

// one-cycle enable every (div_in + 1) system clocks
module sar_clk_div (
   // clock and reset
   input wire core_clk_in,
   input wire nrst_in,
   // control
   input wire run_in,
   input wire [4:0] div_in,
   // enable
   output reg tick_out
);
   reg [4:0] cnt_r;

   always @(posedge core_clk_in) begin
      if (!nrst_in || !run_in) begin
         // restarting keeps phase aligned with each start
         cnt_r <= 5'h00;
         tick_out <= 1'b0;
      end else if (cnt_r >= div_in) begin
         cnt_r <= 5'h00;
         tick_out <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         tick_out <= 1'b0;
      end
   end
endmodule // sar_clk_div

`default_nettype wire

// >>> src/sar_adc_control_and_result.v
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctl_map.vh"

// Behaviour
// - converter_on low holds converter shut down
// - track_select low: track except while converting
// - done flag set when a conversion completes its sixteenth sar clock
// - done flag cleared only by software write
// - conv_active reads one during conversion
// - write one starts only with source 00
// - source field picks write, timers, pin
// - timed tracking three sar clocks, then convert
// - pin mode tracks while low, converts rising
// - window hit sticky until software clears
// - right justify: low eight, high two bits
// - right justify sign extends differential only
// - left justify: high eight, low bits 7-6
// - single unsigned, differential two's complement
// - sar clock is sysclk over divider plus one
// - conversion lasts sixteen sar clocks
module sar_adc_control_and_result (
   // clock and reset
   input wire core_clk_in,
   input wire nrst_in,
   // special-function register bus
   input wire [7:0] sfr_addr_in,
   input wire [7:0] sfr_wdata_in,
   input wire sfr_wr_in,
   input wire sfr_rd_in,
   output reg [7:0] sfr_rdata_out,
   // trigger sources
   input wire timer3_ovf_in,
   input wire timer2_ovf_in,
   input wire convert_start_pin_in,
   // analog sar core
   input wire [9:0] sar_code_in,
   input wire differential_in,
   input wire window_match_in,
   output reg analog_enable_out,
   output reg track_out,
   output reg convert_out,
   output reg sar_tick_out
);
   localparam ST_IDLE = 2'd0;
   localparam ST_TRACK = 2'd1;
   localparam ST_CONV = 2'd2;
   localparam [7:0] CFG_RESET = `RST_CONFIG;

   reg converter_on_r;
   reg track_select_r;
   reg conv_done_flag_r;
   reg [1:0] start_source_sel_r;
   reg window_hit_flag_r;
   reg justify_left_sel_r;
   reg [4:0] sar_clock_divider_r;
   reg [2:0] gain_r;
   reg [7:0] result_low_byte_r;
   reg [7:0] result_high_byte_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [4:0] sar_cnt_r;
   reg pin_meta_r;
   reg pin_sync_r;
   reg pin_prev_r;
   reg win_meta_r;
   reg win_sync_r;
   wire sar_tick;
   wire pin_rise;
   wire ctl_wr;
   wire cfg_wr;
   wire low_wr;
   wire high_wr;
   wire busy_write_start;
   wire on_now;
   wire track_now;
   wire [1:0] src_now;
   wire track_end;
   reg trigger;
   wire conv_active;
   wire conv_end;
   reg [7:0] low_fmt;
   reg [7:0] high_fmt;

   // register decode shared by the write strobes
   function addr_hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   // true on the sar tick that closes a phase of total ticks
   function phase_last_tick;
      input tick;
      input [4:0] cnt;
      input [4:0] total;
      begin
         phase_last_tick = tick && (cnt == total - 5'h01);
      end
   endfunction

   // busy is both the timed tracking and the conversion phases
   assign conv_active = (state_r != ST_IDLE);
   assign ctl_wr = sfr_wr_in && addr_hit(sfr_addr_in, `ADDR_CONTROL);
   assign cfg_wr = sfr_wr_in && addr_hit(sfr_addr_in, `ADDR_CONFIG);
   assign low_wr = sfr_wr_in && addr_hit(sfr_addr_in, `ADDR_RESULT_LOW);
   assign high_wr = sfr_wr_in && addr_hit(sfr_addr_in, `ADDR_RESULT_HIGH);
   // a control write acts on its own edge, so one write can enable and start
   assign on_now = ctl_wr ? sfr_wdata_in[`BIT_CONVERTER_ON] : converter_on_r;
   assign track_now = ctl_wr ? sfr_wdata_in[`BIT_TRACK_SELECT] : track_select_r;
   assign src_now = ctl_wr ? sfr_wdata_in[`BIT_SRC_HI:`BIT_SRC_LO] : start_source_sel_r;
   assign busy_write_start = ctl_wr && sfr_wdata_in[`BIT_CONV_ACTIVE]
      && (src_now == `SRC_WRITE);
   assign pin_rise = pin_sync_r && !pin_prev_r;
   assign track_end = (state_r == ST_TRACK) && phase_last_tick(sar_tick, sar_cnt_r, `TRACK_SAR_CLOCKS);
   assign conv_end = (state_r == ST_CONV) && phase_last_tick(sar_tick, sar_cnt_r, `CONV_SAR_CLOCKS);

   sar_clk_div u_div (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .run_in(conv_active),
      .div_in(sar_clock_divider_r),
      .tick_out(sar_tick)
   );

   // the pin and window match come from outside this clock domain
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         pin_meta_r <= 1'b1;
         pin_sync_r <= 1'b1;
         pin_prev_r <= 1'b1;
         win_meta_r <= 1'b0;
         win_sync_r <= 1'b0;
      end else begin
         pin_meta_r <= convert_start_pin_in;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
         win_meta_r <= window_match_in;
         win_sync_r <= win_meta_r;
      end
   end

   always @* begin
      case (src_now)
         `SRC_WRITE: trigger = busy_write_start;
         `SRC_TIMER3: trigger = timer3_ovf_in;
         `SRC_PIN: trigger = pin_rise;
         `SRC_TIMER2: trigger = timer2_ovf_in;
         default: trigger = 1'b0;
      endcase
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            // triggers while disabled or busy are dropped
            if (on_now && trigger) begin
               if (track_now && (src_now != `SRC_PIN))
                  state_nxt = ST_TRACK;
               else
                  state_nxt = ST_CONV;
            end
         end
         ST_TRACK: begin
            if (track_end)
               state_nxt = ST_CONV;
         end
         ST_CONV: begin
            if (conv_end)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (!on_now)
         state_nxt = ST_IDLE;
   end

   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         state_r <= ST_IDLE;
         sar_cnt_r <= 5'h00;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r)
            sar_cnt_r <= 5'h00;
         else if (sar_tick)
            sar_cnt_r <= sar_cnt_r + 5'h01;
      end
   end

   // format the code in both justifications
   always @* begin
      if (justify_left_sel_r) begin
         high_fmt = sar_code_in[9:2];
         low_fmt = {sar_code_in[1:0], 6'h00};
      end else begin
         low_fmt = sar_code_in[7:0];
         // differential codes are already two's complement from the core
         high_fmt = {{6{differential_in & sar_code_in[9]}}, sar_code_in[9:8]};
      end
   end

   // control fields change only on a control write
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         converter_on_r <= 1'b0;
         track_select_r <= 1'b0;
         start_source_sel_r <= `SRC_WRITE;
         justify_left_sel_r <= 1'b0;
      end else if (ctl_wr) begin
         converter_on_r <= sfr_wdata_in[`BIT_CONVERTER_ON];
         track_select_r <= sfr_wdata_in[`BIT_TRACK_SELECT];
         start_source_sel_r <= sfr_wdata_in[`BIT_SRC_HI:`BIT_SRC_LO];
         justify_left_sel_r <= sfr_wdata_in[`BIT_JUSTIFY_LEFT];
      end
   end

   // sticky flags: a hardware set wins over a same-cycle software clear
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         conv_done_flag_r <= 1'b0;
         window_hit_flag_r <= 1'b0;
      end else begin
         if (conv_end)
            conv_done_flag_r <= 1'b1;
         else if (ctl_wr)
            conv_done_flag_r <= sfr_wdata_in[`BIT_CONV_DONE];
         if (win_sync_r)
            window_hit_flag_r <= 1'b1;
         else if (ctl_wr)
            window_hit_flag_r <= sfr_wdata_in[`BIT_WINDOW_HIT];
      end
   end

   // the gain field is only stored; the amplifier sits outside this block
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         sar_clock_divider_r <= CFG_RESET[`CFG_DIV_HI:`CFG_DIV_LO];
         gain_r <= CFG_RESET[2:0];
      end else if (cfg_wr) begin
         sar_clock_divider_r <= sfr_wdata_in[`CFG_DIV_HI:`CFG_DIV_LO];
         gain_r <= sfr_wdata_in[2:0];
      end
   end

   // both bytes load on one edge so a reader never sees a mixed pair
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         result_low_byte_r <= `RST_RESULT;
         result_high_byte_r <= `RST_RESULT;
      end else if (conv_end) begin
         result_low_byte_r <= low_fmt;
         result_high_byte_r <= high_fmt;
      end else begin
         if (low_wr)
            result_low_byte_r <= sfr_wdata_in;
         if (high_wr)
            result_high_byte_r <= sfr_wdata_in;
      end
   end

   // tracking level seen by the analog core
   always @(posedge core_clk_in) begin
      if (!nrst_in)
         track_out <= 1'b0;
      else if (!converter_on_r)
         track_out <= 1'b0;
      else if (!track_select_r)
         track_out <= (state_r != ST_CONV);
      else if (start_source_sel_r == `SRC_PIN)
         track_out <= (state_r == ST_IDLE) && !pin_sync_r;
      else
         track_out <= (state_r == ST_TRACK);
   end

   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         sfr_rdata_out <= 8'h00;
         analog_enable_out <= 1'b0;
         convert_out <= 1'b0;
         sar_tick_out <= 1'b0;
      end else begin
         analog_enable_out <= converter_on_r;
         convert_out <= (state_r == ST_CONV);
         sar_tick_out <= sar_tick;
         if (sfr_rd_in) begin
            case (sfr_addr_in)
               `ADDR_CONTROL: sfr_rdata_out <= {converter_on_r, track_select_r, conv_done_flag_r,
                  conv_active, start_source_sel_r, window_hit_flag_r, justify_left_sel_r};
               `ADDR_RESULT_LOW: sfr_rdata_out <= result_low_byte_r;
               `ADDR_RESULT_HIGH: sfr_rdata_out <= result_high_byte_r;
               `ADDR_CONFIG: sfr_rdata_out <= {sar_clock_divider_r, gain_r};
               default: sfr_rdata_out <= 8'h00;
            endcase
         end
      end
   end
endmodule // sar_adc_control_and_result

`default_nettype wire

// >>> dv/sar_adc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_monitor (
   // design ports
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic analog_enable_out,
   input wire logic track_out,
   input wire logic convert_out,
   input wire logic sar_tick_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   logic [5:0] ticks_r;
   always @(posedge core_clk_in) begin
      if (!convert_out) ticks_r <= 6'h00;
      else if (sar_tick_out) ticks_r <= ticks_r + 6'h01;
   end
   sequence s_ctl_wr(b);
      sfr_wr_in && sfr_addr_in == 8'he8 && sfr_wdata_in[7] == b;
   endsequence
   sequence s_start;
      s_ctl_wr(1'b1) ##0 sfr_wdata_in[6:2] == 5'b00100 && !convert_out;
   endsequence
   a_off_shuts: assert property (s_ctl_wr(1'b0) |-> ##2 !analog_enable_out) else $error("converter stays on");
   a_on_enables: assert property (s_ctl_wr(1'b1) |-> ##2 analog_enable_out) else $error("converter not on");
   a_off_idle: assert property (!analog_enable_out && !$past(analog_enable_out) |-> !convert_out)
      else $error("converting while off");
   a_track_excl: assert property (!(track_out && convert_out)) else $error("tracking while converting");
   a_conv_ticks: assert property ($fell(convert_out) && analog_enable_out |-> ticks_r inside {[15:16]})
      else $error("wrong conversion length");
   a_unmapped_zero: assert property (sfr_rd_in && !(sfr_addr_in inside {8'hbe, 8'hbf, 8'hbc, 8'he8})
      |=> sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
   a_rdata_holds: assert property (!$past(sfr_rd_in) |-> $stable(sfr_rdata_out)) else $error("read data moved");
   a_write_starts: assert property (s_start |-> ##[1:4] convert_out) else $error("write did not start");
endmodule // sar_adc_monitor
bind sar_adc_control_and_result sar_adc_monitor mon (.core_clk_in, .nrst_in, .sfr_addr_in, .sfr_wdata_in,
   .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .analog_enable_out, .track_out, .convert_out, .sar_tick_out);
`default_nettype wire

// >>> dv/adc_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module adc_far_side (
   // clock and requests from the bench
   input wire logic core_clk_in,
   input wire logic go_in,
   input wire logic [1:0] which_in,
   input wire logic [9:0] code_in,
   input wire logic convert_in,
   // towards the design
   output logic timer3_ovf_out = 1'b0,
   output logic timer2_ovf_out = 1'b0,
   output logic pin_out = 1'b0,
   output logic [9:0] code_out
);
   logic [2:0] hold_r = 3'h0;
   always @(posedge core_clk_in) begin
      timer3_ovf_out <= go_in && which_in == 2'h1;
      timer2_ovf_out <= go_in && which_in == 2'h3;
      if (go_in && which_in == 2'h2) hold_r <= 3'h4;
      else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
      pin_out <= (go_in && which_in == 2'h2) || hold_r > 3'h1;
   end
   // outside a conversion the core output is not valid, so it shows garbage
   assign code_out = convert_in ? code_in : ~code_in;
endmodule // adc_far_side
`default_nettype wire

// >>> dv/sar_adc_control_and_result_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(e, g, s) begin checks++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", s, e, g); end end
module sar_adc_control_and_result_tb_top;
   logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, diff = 1'b0, win = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, q, ctl;
   logic [1:0] which = 2'h0;
   logic [9:0] code = 10'h000, code_w;
   logic t3, t2, pin, aen, trk, cnv, tck;
   int fail_count = 0, checks = 0, cyc = 0, n = 0;
   sar_adc_control_and_result DUT (.core_clk_in(clk), .nrst_in(nrst), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
      .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .timer3_ovf_in(t3), .timer2_ovf_in(t2),
      .convert_start_pin_in(pin), .sar_code_in(code_w), .differential_in(diff), .window_match_in(win),
      .analog_enable_out(aen), .track_out(trk), .convert_out(cnv), .sar_tick_out(tck));
   adc_far_side far (.core_clk_in(clk), .go_in(go), .which_in(which), .code_in(code), .convert_in(cnv),
      .timer3_ovf_out(t3), .timer2_ovf_out(t2), .pin_out(pin), .code_out(code_w));
   initial forever #50 clk = ~clk;
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         conclude;
      end
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input string s);
      logic [7:0] v;
      rd_reg(a, v);
      `CHK(e, v, s)
   endtask
   task automatic fire(input logic [1:0] w);
      @(posedge clk);
      which <= w;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      chk_reg(8'he8, 8'h00, "ctl");
      chk_reg(8'hbe, 8'h00, "lo");
      chk_reg(8'hbf, 8'h00, "hi");
      chk_reg(8'hbc, 8'hf8, "cfg");
      chk_reg(8'h00, 8'h00, "unmapped");
      // divider zero gives a sar tick every cycle and keeps the run short
      wr_reg(8'hbc, 8'h00);
      for (int i = 0; i < 8; i++) begin
         ctl = {1'b1, i[2], 2'b00, i[1:0], 1'b0, i[0] ^ i[2]};
         code <= 10'h3ff ^ {i[2:0], 7'h29};
         diff <= i[1] ^ i[2];
         wr_reg(8'he8, ctl | 8'h10);
         if (i[1:0] != 2'h0) begin
            chk_reg(8'he8, ctl, "busy write");
            fire(i[1:0]);
         end
         q = 8'h00;
         repeat (80) if (q[5] !== 1'b1) rd_reg(8'he8, q);
         `CHK(ctl | 8'h20, q, "done")
         `CHK(1'b0, cnv, "convert idle")
         chk_reg(8'hbe, ctl[0] ? {code[1:0], 6'h00} : code[7:0], "lo");
         chk_reg(8'hbf, ctl[0] ? code[9:2] : {{6{diff & code[9]}}, code[9:8]}, "hi");
         wr_reg(8'he8, ctl);
         chk_reg(8'he8, ctl, "done clear");
         `CHK(!i[2] || i[1:0] == 2'h2, trk, "track")
      end
      @(posedge clk);
      win <= 1'b1;
      repeat (3) @(posedge clk);
      win <= 1'b0;
      repeat (4) @(posedge clk);
      chk_reg(8'he8, ctl | 8'h02, "window");
      wr_reg(8'he8, ctl);
      chk_reg(8'he8, ctl, "window clear");
      // divider two: sixteen ticks of three cycles, plus the edge that ends the phase
      wr_reg(8'hbc, 8'h10);
      wr_reg(8'he8, 8'h90);
      n = 0;
      repeat (100) begin
         @(posedge clk);
         if (cnv === 1'b1) n++;
      end
      `CHK(16 * 3 + 1, n, "conversion cycles")
      wr_reg(8'he8, 8'h14);
      fire(2'h1);
      chk_reg(8'he8, 8'h04, "off");
      `CHK(1'b0, trk, "track off")
      `CHK(1'b0, aen, "enable off")
      conclude;
   end
endmodule // sar_adc_control_and_result_tb_top
`default_nettype wire
